/* File: logic/in_sync.sv */
// in_sync: two-flop synchroniser for the card's asynchronous inputs
// assumes inputs arrive from the card pins with no relation to clk
`timescale 1ns/1ns
`include "socket_ctrl_defines.svh"
module in_sync (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // raw pins and their synchronised copies
   input  wire logic [`SYNC_W-1:0]   pin_in,
   output logic      [`SYNC_W-1:0]   pin_sync
);
   // one two-stage chain per bit; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
         logic meta_reg;  // first stage
         logic sync_reg;  // second stage
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_reg <= 1'h1;
               sync_reg <= 1'h1;
            end else begin
               meta_reg <= pin_in[i];
               sync_reg <= meta_reg;
            end
         end
         assign pin_sync[i] = sync_reg;
      end
   endgenerate
endmodule // in_sync

/* File: logic/socket_ctrl.sv */
// socket_ctrl: control signalling of one 16-bit card socket
// assumes host request logic on clk; card pins are asynchronous to clk
// Operation
// RULE_01 - output enable low on memory reads
// RULE_02 - output enable marks terminal count, dma write
// RULE_03 - memory card ready low while busy
// RULE_04 - i/o card requests service on ready pin
// RULE_05 - attribute select high for common memory
// RULE_06 - attribute select is dma acknowledge with strobes
// RULE_07 - card reset output hard-resets the card
// RULE_08 - wait active holds the cycle open
// RULE_09 - write enable strobes memory write data
// RULE_10 - write enable marks terminal count, dma read
// RULE_11 - card shows write-protect switch state
// RULE_12 - i/o card flags 16-bit port on decode
// RULE_13 - write-protect pin may be dma request
// RULE_14 - two voltage-sense lines decoded together only
// RULE_15 - i/o read strobe for reads, dma write
// RULE_16 - i/o write strobe for writes, dma read
// RULE_17 - input acknowledge answers reads or requests dma
// RULE_18 - strobes and attribute select idle high between cycles
`timescale 1ns/1ns
module socket_ctrl (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // host request side
   input  wire logic                       req_valid,
   input  socket_ctrl_pkg::cyc_kind_t      req_kind,
   input  wire logic                       req_last,
   output logic                            req_ready,
   output logic                            cyc_done,
   // host control and status
   input  wire logic                       io_mode,
   input  wire logic                       card_reset_req,
   output logic                            card_ready,
   output logic                            card_interrupt_request,
   output logic                            write_protect,
   output logic                            io_port_width_flag,
   output logic                            dma_req_to_card,
   output logic                            dma_req_from_card,
   output logic                            input_acknowledge,
   output socket_ctrl_pkg::volt_class_t    voltage_class,
   // card control outputs, active low except card_reset
   output logic                            oe_n,
   output logic                            we_n,
   output logic                            reg_n,
   output logic                            io_read_strobe_n,
   output logic                            io_write_strobe_n,
   output logic                            card_reset,
   // card inputs, raw pins
   input  wire logic                       ready_pin,
   input  wire logic                       wait_n_pin,
   input  wire logic                       wp_pin,
   input  wire logic                       input_acknowledge_n_pin,
   // voltage-sense pins, two-way; this end only listens
   input  wire logic                       voltage_sense_first_in,
   output logic                            voltage_sense_first_out,
   output logic                            voltage_sense_first_oe,
   input  wire logic                       voltage_sense_second_in,
   output logic                            voltage_sense_second_out,
   output logic                            voltage_sense_second_oe
);
   `include "socket_ctrl_defines.svh"

   // decode of the two sense lines as one pair
   function automatic socket_ctrl_pkg::volt_class_t vs_decode(input logic first,
                                                               input logic second);
      vs_decode = socket_ctrl_pkg::volt_class_t'({first, second});
   endfunction

   // synchronised card inputs
   logic [`SYNC_W-1:0]               pin_raw;    // raw pin vector
   logic [`SYNC_W-1:0]               pin_sync;   // after two flops
   logic                             wait_act;   // card stretching the cycle

   assign pin_raw = {1'h1, voltage_sense_second_in, voltage_sense_first_in,
                     input_acknowledge_n_pin, wp_pin, ready_pin, wait_n_pin};

   in_sync u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .pin_in   (pin_raw),
      .pin_sync (pin_sync)
   );

   assign wait_act = !pin_sync[`SI_WAIT];

   // sequencer state
   socket_ctrl_pkg::cyc_state_t      state_reg;  // current state
   socket_ctrl_pkg::cyc_state_t      state_next; // next state
   socket_ctrl_pkg::cyc_kind_t       kind_reg;   // cycle kind held
   logic                             last_reg;   // dma word is the last
   logic [`CNT_W-1:0]                cnt_reg;    // phase countdown
   logic [`CNT_W-1:0]                cnt_next;   // next countdown

   // kind decode of the held cycle
   wire is_mem_rd  = (kind_reg == socket_ctrl_pkg::CYC_MEM_RD);
   wire is_attr_rd = (kind_reg == socket_ctrl_pkg::CYC_ATTR_RD);
   wire is_mem_wr  = (kind_reg == socket_ctrl_pkg::CYC_MEM_WR);
   wire is_attr_wr = (kind_reg == socket_ctrl_pkg::CYC_ATTR_WR);
   wire is_io_rd   = (kind_reg == socket_ctrl_pkg::CYC_IO_RD);
   wire is_io_wr   = (kind_reg == socket_ctrl_pkg::CYC_IO_WR);
   wire is_dma_rd  = (kind_reg == socket_ctrl_pkg::CYC_DMA_RD);
   wire is_dma_wr  = (kind_reg == socket_ctrl_pkg::CYC_DMA_WR);
   wire is_common  = is_mem_rd | is_mem_wr;

   // strobe selection for the held cycle
   wire oe_sel   = is_mem_rd | is_attr_rd | (is_dma_wr & last_reg);  // RULE_01 RULE_02
   wire we_sel   = is_mem_wr | is_attr_wr | (is_dma_rd & last_reg);  // RULE_09 RULE_10
   wire io_read_strobe_sel = is_io_rd | is_dma_wr;                             // RULE_15
   wire io_write_strobe_sel = is_io_wr | is_dma_rd;                             // RULE_16
   wire reg_sel  = !is_common;                                       // RULE_05 RULE_06
   // a cycle taken this clock sets attribute select by its own kind, not the held one
   wire reg_want = (req_valid && req_ready) ?
                   !(req_kind == socket_ctrl_pkg::CYC_MEM_RD ||
                     req_kind == socket_ctrl_pkg::CYC_MEM_WR) : reg_sel;  // RULE_05 RULE_06

   // phases in the next cycle
   wire next_strobe = (state_next == socket_ctrl_pkg::ST_STROBE);
   wire next_busy   = next_strobe | (state_next == socket_ctrl_pkg::ST_SETUP);

   // next state and countdown
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         socket_ctrl_pkg::ST_IDLE: begin
            if (req_valid && !card_reset) begin
               state_next = socket_ctrl_pkg::ST_SETUP;
               cnt_next   = `CNT_W'(`SETUP_CYC - 1);
            end
         end
         socket_ctrl_pkg::ST_SETUP: begin
            if (cnt_reg == `CNT_W'h0) begin
               state_next = socket_ctrl_pkg::ST_STROBE;
               cnt_next   = `CNT_W'(`STROBE_CYC - 1);
            end else begin
               cnt_next = cnt_reg - `CNT_W'h1;
            end
         end
         socket_ctrl_pkg::ST_STROBE: begin
            // strobe ends only after its least width and once wait is gone
            if (cnt_reg != `CNT_W'h0) begin
               cnt_next = cnt_reg - `CNT_W'h1;
            end else if (!wait_act) begin  // RULE_08
               state_next = socket_ctrl_pkg::ST_RECOVER;
            end
         end
         socket_ctrl_pkg::ST_RECOVER: begin
            state_next = socket_ctrl_pkg::ST_IDLE;
         end
         default: begin
            state_next = socket_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= socket_ctrl_pkg::ST_IDLE;
         cnt_reg   <= `CNT_W'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // request capture when accepted
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         kind_reg <= socket_ctrl_pkg::CYC_MEM_RD;
         last_reg <= 1'h0;
      end else if (req_valid && req_ready) begin
         kind_reg <= req_kind;
         last_reg <= req_last;
      end
   end

   // card strobes from flops; all idle high outside a cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oe_n              <= 1'h1;  // RULE_18
         we_n              <= 1'h1;
         io_read_strobe_n  <= 1'h1;
         io_write_strobe_n <= 1'h1;
         reg_n             <= 1'h1;
      end else begin
         oe_n              <= !(next_strobe && oe_sel);    // RULE_01 RULE_02 RULE_18
         we_n              <= !(next_strobe && we_sel);    // RULE_09 RULE_10 RULE_18
         io_read_strobe_n  <= !(next_strobe && io_read_strobe_sel);  // RULE_15 RULE_18
         io_write_strobe_n <= !(next_strobe && io_write_strobe_sel);  // RULE_16 RULE_18
         reg_n             <= !(next_busy && reg_want);    // RULE_05 RULE_06 RULE_18
      end
   end

   // card reset output and cycle completion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         card_reset <= 1'h1;
         cyc_done   <= 1'h0;
      end else begin
         card_reset <= card_reset_req;  // RULE_07
         cyc_done   <= (state_reg == socket_ctrl_pkg::ST_STROBE) &&
                       (state_next == socket_ctrl_pkg::ST_RECOVER);
      end
   end

   // handshake: a request is taken only in idle with the card out of reset
   assign req_ready = (state_reg == socket_ctrl_pkg::ST_IDLE) && !card_reset;

   // card status from the synchronised pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         card_ready             <= 1'h0;
         card_interrupt_request <= 1'h0;
         write_protect          <= 1'h0;
         io_port_width_flag     <= 1'h0;
         dma_req_to_card        <= 1'h0;
         dma_req_from_card      <= 1'h0;
         input_acknowledge      <= 1'h0;
         voltage_class          <= socket_ctrl_pkg::VC_BOTH_OPEN;
      end else begin
         card_ready             <= !io_mode && pin_sync[`SI_READY];   // RULE_03
         card_interrupt_request <= io_mode && !pin_sync[`SI_READY];   // RULE_04
         write_protect          <= !io_mode && pin_sync[`SI_WP];      // RULE_11
         io_port_width_flag     <= io_mode && !pin_sync[`SI_WP];      // RULE_12
         dma_req_to_card        <= pin_sync[`SI_WP];                  // RULE_13
         dma_req_from_card      <= pin_sync[`SI_INPUT_ACKNOWLEDGE];              // RULE_17
         input_acknowledge      <= !pin_sync[`SI_INPUT_ACKNOWLEDGE];             // RULE_17
         voltage_class          <= vs_decode(pin_sync[`SI_VS1],
                                             pin_sync[`SI_VS2]);     // RULE_14
      end
   end

   // sense pins are only read here
   assign voltage_sense_first_out  = 1'h0;
   assign voltage_sense_first_oe   = 1'h0;
   assign voltage_sense_second_out = 1'h0;
   assign voltage_sense_second_oe  = 1'h0;

   // checks on the card-facing behaviour
   property p_idle_quiet;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == socket_ctrl_pkg::ST_IDLE) |=>
         $past(state_next) != socket_ctrl_pkg::ST_IDLE ||
         (oe_n && we_n && reg_n && io_read_strobe_n && io_write_strobe_n);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("strobe active outside a cycle"); // RULE_18

   property p_oe_cause;
      @(posedge clk) disable iff (!rst_n)
      !oe_n |-> state_reg == socket_ctrl_pkg::ST_STROBE && oe_sel;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("output enable without cause"); // RULE_01

   property p_dma_wr_tc;
      @(posedge clk) disable iff (!rst_n)
      state_reg == socket_ctrl_pkg::ST_STROBE && is_dma_wr && last_reg |-> !oe_n && we_n;
   endproperty
   a_dma_wr_tc: assert property (p_dma_wr_tc) else $error("dma write count missing"); // RULE_02

   property p_dma_rd_tc;
      @(posedge clk) disable iff (!rst_n)
      state_reg == socket_ctrl_pkg::ST_STROBE && is_dma_rd && last_reg |-> !we_n && oe_n;
   endproperty
   a_dma_rd_tc: assert property (p_dma_rd_tc) else $error("dma read count missing"); // RULE_10

   property p_common_reg;
      @(posedge clk) disable iff (!rst_n)
      state_reg != socket_ctrl_pkg::ST_IDLE && is_common |-> reg_n;
   endproperty
   a_common_reg: assert property (p_common_reg) else $error("attribute select on common access"); // RULE_05

   property p_dma_acknowledge;
      @(posedge clk) disable iff (!rst_n)
      state_reg == socket_ctrl_pkg::ST_STROBE && (is_dma_rd || is_dma_wr) |->
         !reg_n && (is_dma_rd ? !io_write_strobe_n : !io_read_strobe_n);
   endproperty
   a_dma_acknowledge: assert property (p_dma_acknowledge) else $error("dma acknowledge or strobe missing"); // RULE_06

   property p_wait_hold;
      @(posedge clk) disable iff (!rst_n)
      state_reg == socket_ctrl_pkg::ST_STROBE && cnt_reg == `CNT_W'h0 && wait_act |=>
         state_reg == socket_ctrl_pkg::ST_STROBE && !cyc_done;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("cycle ended during wait"); // RULE_08

   property p_strobe_width;
      @(posedge clk) disable iff (!rst_n)
      $rose(state_reg == socket_ctrl_pkg::ST_STROBE) |->
         (state_reg == socket_ctrl_pkg::ST_STROBE) [*3];
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // RULE_09

   property p_reset_follow;
      @(posedge clk) disable iff (!rst_n)
      card_reset_req |=> card_reset ##0 req_ready == 1'h0;
   endproperty
   a_reset_follow: assert property (p_reset_follow) else $error("card reset not driven"); // RULE_07

   property p_vs_pair;
      @(posedge clk) disable iff (!rst_n)
      1'h1 |=> voltage_class == vs_decode($past(pin_sync[`SI_VS1]), $past(pin_sync[`SI_VS2]));
   endproperty
   a_vs_pair: assert property (p_vs_pair) else $error("voltage class not from both lines"); // RULE_14

   // main scenarios
   c_mem_read: cover property (@(posedge clk) disable iff (!rst_n) !oe_n && reg_n);
   c_io_write: cover property (@(posedge clk) disable iff (!rst_n) !io_write_strobe_n && !reg_n);
   c_dma_tc:   cover property (@(posedge clk) disable iff (!rst_n) !we_n && !io_write_strobe_n);
   c_waited:   cover property (@(posedge clk) disable iff (!rst_n)
                               state_reg == socket_ctrl_pkg::ST_STROBE && cnt_reg == `CNT_W'h0
                               && wait_act);
endmodule // socket_ctrl

/* File: logic/socket_ctrl_defines.svh */
// socket_ctrl_defines.svh: timing counts and encodings of the card socket control block
// assumes a 10 MHz clk; included by its bare name wherever a figure is needed
`ifndef SOCKET_CTRL_DEFINES_SVH
`define SOCKET_CTRL_DEFINES_SVH

// clock period in ns
`define CLK_PERIOD_NS     100
// least address setup ahead of a strobe, in ns
`define SETUP_TIME_NS     100
// least strobe width, in ns
`define STROBE_TIME_NS    300
// derived cycle counts, least times rounded up
`define SETUP_CYC   ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC  ((`STROBE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// width of the phase counter
`define CNT_W             4
// width of the synchronised input vector: six card inputs and a spare
`define SYNC_W            7
// positions in the synchronised input vector
`define SI_WAIT           0
`define SI_READY          1
`define SI_WP             2
`define SI_INPUT_ACKNOWLEDGE         3
`define SI_VS1            4
`define SI_VS2            5
`define SI_SPARE          6

`endif

/* File: logic/socket_ctrl_pkg.sv */
// socket_ctrl_pkg: types of the card socket control block
// assumes nothing beyond a SystemVerilog compiler
package socket_ctrl_pkg;

   // kind of card cycle asked for by the host side
   typedef enum logic [2:0] {
      CYC_MEM_RD  = 3'h0,  // common memory read
      CYC_MEM_WR  = 3'h1,  // common memory write
      CYC_ATTR_RD = 3'h2,  // attribute memory read
      CYC_ATTR_WR = 3'h3,  // attribute memory write
      CYC_IO_RD   = 3'h4,  // i/o read
      CYC_IO_WR   = 3'h5,  // i/o write
      CYC_DMA_RD  = 3'h6,  // dma from host memory to card
      CYC_DMA_WR  = 3'h7   // dma from card to host memory
   } cyc_kind_t;

   // cycle sequencer states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,  // nothing on the card bus
      ST_SETUP   = 3'h1,  // select lines settle ahead of the strobe
      ST_STROBE  = 3'h2,  // strobe low, stretched by wait
      ST_RECOVER = 3'h3   // strobes released, cycle done
   } cyc_state_t;

   // combined reading of the two voltage-sense lines
   typedef enum logic [1:0] {
      VC_BOTH_LOW  = 2'h0,  // both sense lines low
      VC_SECOND_LO = 2'h1,  // first low, second high
      VC_FIRST_LO  = 2'h2,  // first high, second low
      VC_BOTH_OPEN = 2'h3   // both sense lines high
   } volt_class_t;

endpackage

/* File: verification/card_model.sv */
// card_model: behavioural 16-bit card at the far side of one socket
// assumes strobes come from socket_ctrl and pin levels are set by the bench
`timescale 1ns/1ns
module card_model (
   // clock
   input  wire logic       clk,
   // strobes seen from the socket, active low
   input  wire logic       oe_n,
   input  wire logic       we_n,
   input  wire logic       io_read_strobe_n,
   input  wire logic       io_write_strobe_n,
   // levels the card shows and the wait it asks for
   input  wire logic [4:0] lvl,
   input  wire logic [3:0] wait_len,
   // card pins
   output logic            ready_pin,
   output logic            wait_n_pin,
   output logic            wp_pin,
   output logic            input_acknowledge_n_pin,
   output logic            voltage_sense_first_in,
   output logic            voltage_sense_second_in
);
   logic [3:0] wait_cnt = 4'h0;  // clocks of this strobe already waited
   wire        in_cyc;           // some strobe is low
   assign in_cyc = ~(oe_n & we_n & io_read_strobe_n & io_write_strobe_n);
   // busy or service request on the shared ready pin
   assign ready_pin = lvl[0];
   // switch state, 16-bit port flag or dma request
   assign wp_pin = lvl[1];
   // read answer or dma request from the card
   assign input_acknowledge_n_pin = lvl[2];
   // sense lines, grounded or open at the card
   assign voltage_sense_first_in = lvl[3];
   assign voltage_sense_second_in = lvl[4];
   // wait falls with the strobe, so the socket sees it through its synchroniser
   assign wait_n_pin = !(in_cyc && (wait_cnt < wait_len));
   // count strobe clocks waited; cleared between cycles
   always @(posedge clk) begin
      if (!in_cyc) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt < wait_len) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule  // card_model

/* File: verification/tb_pc_card_16bit_socket_control.sv */
// tb_pc_card_16bit_socket_control: self-checking bench of socket_ctrl
// assumes card_model at the far side; inputs change at the falling edge
`timescale 1ns/1ns
`define CHECK_EQ(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin \
   n_errors++; $display("[ERR] %0t %s", $time, msg); end end
module tb_pc_card_16bit_socket_control;
   logic       clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_last = 1'b0;
   logic       io_mode = 1'b0, card_reset_req = 1'b1;
   logic [4:0] lvl = 5'h18;     // card pin levels
   logic [3:0] wait_len = 4'h0; // wait cycles asked of the card
   socket_ctrl_pkg::cyc_kind_t  req_kind = socket_ctrl_pkg::CYC_MEM_RD;
   socket_ctrl_pkg::volt_class_t voltage_class;
   logic req_ready, cyc_done, card_ready, card_interrupt_request, write_protect;
   logic io_port_width_flag, dma_req_to_card, dma_req_from_card, input_acknowledge;
   logic oe_n, we_n, reg_n, io_read_strobe_n, io_write_strobe_n, card_reset;
   logic ready_pin, wait_n_pin, wp_pin, input_acknowledge_n_pin, vs1, vs2;
   int         n_errors = 0, check_count = 0;
   logic [8:0] exp_q[$];        // notes: {least strobe cycles, strobes low}
   logic [8:0] note;            // note taken off the queue
   logic [4:0] seen = 5'h00;    // strobes seen low in this cycle
   logic [3:0] slen = 4'h0;     // strobe cycles counted
   wire  [4:0] act;             // active strobes {oe, we, reg, io_read_strobe, io_write_strobe}
   wire  [8:0] status_v;        // status outputs in one vector
   wire  [3:0] vs_drv;          // sense pin drive and enables from the design
   // strobes of each cycle kind, terminal count added later
   logic [4:0] pat_tab [8] = '{5'h10, 5'h08, 5'h14, 5'h0C, 5'h06, 5'h05, 5'h05, 5'h06};
   assign act = ~{oe_n, we_n, reg_n, io_read_strobe_n, io_write_strobe_n};
   assign status_v = {card_ready, card_interrupt_request, write_protect, io_port_width_flag,
                      dma_req_to_card, dma_req_from_card, input_acknowledge, voltage_class};
   // design under test
   socket_ctrl DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
      .req_last(req_last), .req_ready(req_ready), .cyc_done(cyc_done), .io_mode(io_mode),
      .card_reset_req(card_reset_req), .card_ready(card_ready),
      .card_interrupt_request(card_interrupt_request), .write_protect(write_protect),
      .io_port_width_flag(io_port_width_flag), .dma_req_to_card(dma_req_to_card),
      .dma_req_from_card(dma_req_from_card), .input_acknowledge(input_acknowledge),
      .voltage_class(voltage_class), .oe_n(oe_n), .we_n(we_n), .reg_n(reg_n),
      .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
      .card_reset(card_reset), .ready_pin(ready_pin), .wait_n_pin(wait_n_pin),
      .wp_pin(wp_pin), .input_acknowledge_n_pin(input_acknowledge_n_pin),
      .voltage_sense_first_in(vs1), .voltage_sense_first_out(vs_drv[0]),
      .voltage_sense_first_oe(vs_drv[1]), .voltage_sense_second_in(vs2),
      .voltage_sense_second_out(vs_drv[2]), .voltage_sense_second_oe(vs_drv[3]));
   // far-side card
   card_model card (.clk(clk), .oe_n(oe_n), .we_n(we_n), .io_read_strobe_n(io_read_strobe_n),
      .io_write_strobe_n(io_write_strobe_n), .lvl(lvl), .wait_len(wait_len),
      .ready_pin(ready_pin), .wait_n_pin(wait_n_pin), .wp_pin(wp_pin),
      .input_acknowledge_n_pin(input_acknowledge_n_pin),
      .voltage_sense_first_in(vs1), .voltage_sense_second_in(vs2));
   // 10 MHz clock
   initial begin
      forever #50 clk = ~clk;
   end
   // prints counts and verdict, ends the run
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // a bound ran out
   task automatic time_out;
      n_errors++;
      $display("[ERR] %0t wait bound used up", $time);
      wrap_up;
   endtask
   // one card cycle: note the expectation, hold the request until taken
   task automatic run_cycle(input logic [2:0] k, input logic last, input logic [3:0] w);
      int n;
      logic [4:0] p;
      p = pat_tab[k] | ((last && k == 3'h6) ? 5'h08 : 5'h00);
      p = p | ((last && k == 3'h7) ? 5'h10 : 5'h00);
      exp_q.push_back({(w > 4'h3) ? w : 4'h3, p});
      @(negedge clk);
      wait_len = w;
      req_kind = socket_ctrl_pkg::cyc_kind_t'(k);
      req_last = last;
      req_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      if (n >= 50) time_out;
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (n >= 60) time_out;
   endtask
   // set pin levels and mode, compare status four clocks on
   task automatic check_status(input logic io, input logic [4:0] l);
      logic [8:0] e;
      @(negedge clk);
      io_mode = io;
      lvl = l;
      e = {l[0] & ~io, ~l[0] & io, l[1] & ~io, ~l[1] & io, l[1], l[2], ~l[2], l[3], l[4]};
      repeat (4) @(negedge clk);
      `CHECK_EQ(status_v, e, "status outputs")
      `CHECK_EQ(vs_drv, 4'h0, "sense pins driven")
   endtask
   // watcher: gathers strobes, takes a note at each done pulse
   always @(posedge clk) begin
      if (rst_n === 1'b1 && req_ready === 1'b1) begin
         `CHECK_EQ(act, 5'h00, "strobe active in idle")
      end
      if (cyc_done === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHECK_EQ(1'b0, 1'b1, "done without request")
         end else begin
            note = exp_q.pop_front();
            `CHECK_EQ(seen, note[4:0], "strobe pattern")
            `CHECK_EQ(slen >= note[8:5], 1'b1, "strobe too short")
         end
         seen <= 5'h00;
         slen <= 4'h0;
      end else if (rst_n === 1'b1) begin
         seen <= seen | act;
         if (act[4] | act[3] | act[1] | act[0]) slen <= slen + 4'h1;
      end
   end
   // main sequence
   initial begin
      void'($urandom(87));
      repeat (12) @(negedge clk);
      `CHECK_EQ({act, card_reset, cyc_done, req_ready}, 8'h04, "reset state")
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHECK_EQ({card_reset, req_ready}, 2'h2, "card held in reset")
      card_reset_req = 1'b0;
      @(negedge clk);
      `CHECK_EQ({card_reset, req_ready}, 2'h1, "card reset release")
      $display("test reset done");
      for (int i = 0; i < 8; i++) run_cycle(3'(i), 1'b1, 4'h0);
      run_cycle(3'h0, 1'b0, 4'h7);
      for (int i = 0; i < 24; i++) run_cycle(3'($urandom), 1'($urandom), 4'($urandom % 8));
      $display("test card cycles done");
      for (int i = 0; i < 16; i++) check_status(i[2], {i[1:0], 3'($urandom)});
      $display("test status done");
      @(negedge clk);
      card_reset_req = 1'b1;
      @(negedge clk);
      req_valid = 1'b1;
      repeat (4) @(negedge clk);
      `CHECK_EQ({card_reset, req_ready}, 2'h2, "request refused in reset")
      req_valid = 1'b0;
      card_reset_req = 1'b0;
      run_cycle(3'h5, 1'b0, 4'h2);
      `CHECK_EQ(exp_q.size(), 0, "cycles left unanswered")
      $display("test mid-run card reset done");
      wrap_up;
   end
endmodule  // tb_pc_card_16bit_socket_control
